//--- hdl/mcp_control.sv
// Control pin logic: select gating, reset sequencing, interrupt, low power, presence
// Contract
// - Select low lets module answer serial bus
// - Select high: ignore bus, never drive data
// - Floating select reads as deselected
// - Long enough reset low restores all defaults
// - Init interval timed from reset rising edge
// - Completion shown by interrupt, not-ready cleared
// - Power-up raises completion interrupt without reset
// - Low-power input high enters reduced power
// - Presence output tied low inside module
// - Interrupt low flags fault or critical status
// - Reset low must last two microseconds
// - Fully functional within 2000 ms of release
// - Not-ready flag is byte 2 bit 0
// - Read clears flag; interrupt released quickly
`timescale 1ns/1ps
`default_nettype none
module mcp_control
    import mcp_pkg::*;
#(
    parameter int unsigned INIT_CYC  = INIT_CYC_DEFAULT,
    parameter int unsigned RESET_CYC = RESET_MIN_CYC
)(
    // Clock and power-on reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Host control pins
    input  wire logic module_select_pin,
    input  wire logic module_reset_pin_n,
    input  wire logic low_power_request,
    // Serial bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Serial slave core side
    output logic      slave_enable,
    input  wire logic slave_sda_pull,
    input  wire logic status2_read,
    input  wire logic fault_event,
    // Status and module-wide controls
    output logic [7:0] status2,
    output logic       settings_reset,
    output logic       reduced_power,
    // Presence and interrupt pins
    output logic      module_present_out,
    output logic      module_present_oe,
    output logic      interrupt_out,
    output logic      interrupt_oe
);
    mcp_sync_if sync ();

    mcp_pin_sync u_sync (
        .core_clk          (core_clk),
        .nrst              (nrst),
        .module_select_pin (module_select_pin),
        .module_reset_n    (module_reset_pin_n),
        .low_power_request (low_power_request),
        .scl_in            (scl_in),
        .sda_in            (sda_in),
        .sync              (sync.src)
    );

    mcp_state_t  state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic        dnr_reg, dnr_next;
    logic        done_flag_reg, done_flag_next;
    logic        fault_flag_reg, fault_flag_next;
    logic        reset_hit_reg, reset_hit_next;
    logic [31:0] low_cnt_reg, low_cnt_next;

    // Pull-up on the pin means a floating select arrives high here
    wire selected     = ~sync.select_n;
    wire reset_low    = ~sync.reset_n;
    wire reset_valid  = reset_low && (low_cnt_reg >= RESET_CYC - 1);
    wire init_done    = (state_reg == MCP_ST_INIT) && (cnt_reg >= INIT_CYC - 1);

    // Low time of the reset pin, kept apart from the init timer so that a
    // pulse is measured in any state; it saturates so a long hold stays valid
    assign low_cnt_next = !reset_low ? 32'd0 :
                          (low_cnt_reg < RESET_CYC) ? low_cnt_reg + 32'd1 : low_cnt_reg;

    // Sequencer: hold while reset pin low, time init from its release
    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        dnr_next        = dnr_reg;
        done_flag_next  = done_flag_reg;
        fault_flag_next = fault_flag_reg;
        reset_hit_next  = 1'b0;
        case (state_reg)
            MCP_ST_HOLD: begin
                if (!reset_low) begin
                    // Pin back high: the init interval starts from here
                    state_next = MCP_ST_INIT;
                    cnt_next   = 32'd0;
                end
            end
            MCP_ST_INIT: begin
                if (init_done) begin
                    state_next     = MCP_ST_RUN;
                    dnr_next       = 1'b0;
                    done_flag_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 32'd1;
                end
            end
            MCP_ST_RUN: begin
                cnt_next = 32'd0;
            end
            default: begin
                state_next = MCP_ST_HOLD;
            end
        endcase
        if (reset_valid) begin
            state_next      = MCP_ST_HOLD;
            dnr_next        = 1'b1;
            done_flag_next  = 1'b0;
            fault_flag_next = 1'b0;
            reset_hit_next  = 1'b1;
        end else begin
            // Read clears; a new event in the same cycle wins
            if (status2_read && state_reg == MCP_ST_RUN) begin
                done_flag_next  = 1'b0;
                fault_flag_next = 1'b0;
            end
            if (fault_event && state_reg == MCP_ST_RUN) begin
                fault_flag_next = 1'b1;
            end
        end
    end

    // Sequencer state; power-on starts in init so completion follows by itself
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= MCP_ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Init interval timer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 32'd0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Reset pin low-time counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_reg <= 32'd0;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    // Not-ready flag, set from power-on until init has finished
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dnr_reg <= 1'b1;
        end else begin
            dnr_reg <= dnr_next;
        end
    end

    // Completion flag, one reason for the interrupt
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            done_flag_reg <= 1'b0;
        end else begin
            done_flag_reg <= done_flag_next;
        end
    end

    // Fault flag, the other reason for the interrupt
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fault_flag_reg <= 1'b0;
        end else begin
            fault_flag_reg <= fault_flag_next;
        end
    end

    // Registered mark of an accepted reset request, high for every cycle it stays valid
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reset_hit_reg <= 1'b0;
        end else begin
            reset_hit_reg <= reset_hit_next;
        end
    end

    // Serial bus gating; bus answered only while selected and running
    assign slave_enable = selected && (state_reg == MCP_ST_RUN);
    assign sda_out      = 1'b0;
    assign sda_oe       = slave_enable && slave_sda_pull;

    // Status byte 2 with not-ready in bit 0
    assign status2        = {7'h00, dnr_reg};
    assign settings_reset = reset_hit_reg | (state_reg == MCP_ST_HOLD);

    // Low power level passes straight to the power controller
    // No filtering: each change of the pin shows two cycles later
    assign reduced_power = sync.low_power;

    // Presence: always pulled to ground while the module is fitted
    assign module_present_out = 1'b0;
    assign module_present_oe  = 1'b1;

    // Open collector interrupt; released the cycle after a clearing read
    // Completion and fault share the pin; one read of byte 2 clears both
    assign interrupt_out = 1'b0;
    assign interrupt_oe  = done_flag_reg | fault_flag_reg;
endmodule : mcp_control
`default_nettype wire

//--- hdl/mcp_pin_sync.sv
// Two-stage synchronisers for the host-driven control pins
`timescale 1ns/1ps
`default_nettype none
module mcp_pin_sync
    import mcp_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Raw pins
    input  wire logic module_select_pin,
    input  wire logic module_reset_n,
    input  wire logic low_power_request,
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Synchronised levels
    mcp_sync_if.src   sync
);
    logic [4:0] stage1_reg;
    logic [4:0] stage2_reg;
    wire  [4:0] raw_pins = {module_select_pin, module_reset_n, low_power_request, scl_in, sda_in};

    // Idle value is all high except low power, matching the pull-ups
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= 5'h1b;
            stage2_reg <= 5'h1b;
        end else begin
            stage1_reg <= raw_pins;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync.select_n  = stage2_reg[4];
    assign sync.reset_n   = stage2_reg[3];
    assign sync.low_power = stage2_reg[2];
    assign sync.scl       = stage2_reg[1];
    assign sync.sda       = stage2_reg[0];
endmodule : mcp_pin_sync
`default_nettype wire

//--- hdl/mcp_pkg.sv
// Constants for the module control pin block
package mcp_pkg;
    localparam int unsigned CLK_HZ            = 40000000;
    localparam int unsigned RESET_MIN_US      = 2;
    localparam int unsigned RESET_MIN_CYC     = (RESET_MIN_US * (CLK_HZ / 1000000));
    localparam int unsigned INIT_MAX_MS       = 2000;
    localparam int unsigned INIT_MAX_CYC      = INIT_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned INIT_CYC_DEFAULT  = 1000;
    localparam int unsigned INT_OFF_MAX_US    = 500;
    localparam int unsigned INT_OFF_MAX_CYC   = INT_OFF_MAX_US * (CLK_HZ / 1000000);
    localparam int unsigned STATUS_BYTE_DNR   = 2;
    localparam int unsigned DNR_BIT           = 0;
    localparam logic [7:0]  STATUS2_RESET     = 8'h01;
    localparam int unsigned SYNC_STAGES       = 2;

    typedef enum logic [1:0] {
        MCP_ST_HOLD = 2'b00,
        MCP_ST_INIT = 2'b01,
        MCP_ST_RUN  = 2'b10
    } mcp_state_t;
endpackage : mcp_pkg

//--- hdl/mcp_sync_if.sv
// Carrier for synchronised pin levels between the pin stage and the core
`timescale 1ns/1ps
`default_nettype none
interface mcp_sync_if;
    logic select_n;
    logic reset_n;
    logic low_power;
    logic scl;
    logic sda;
    modport src (output select_n, output reset_n, output low_power, output scl, output sda);
    modport dst (input select_n, input reset_n, input low_power, input scl, input sda);
endinterface : mcp_sync_if
`default_nettype wire

//--- verification/mcp_control_monitor.sv
// Port checks for the control pin block
`timescale 1ns/1ps
`default_nettype none
module mcp_control_monitor
    import mcp_pkg::*;
#(
    parameter int unsigned INIT_CYC  = INIT_CYC_DEFAULT,
    parameter int unsigned RESET_CYC = RESET_MIN_CYC
)(
    // Clock and resets
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       module_reset_pin_n,
    // Host pins and slave core inputs
    input wire logic       module_select_pin,
    input wire logic       low_power_request,
    input wire logic       slave_sda_pull,
    input wire logic       status2_read,
    input wire logic       fault_event,
    // Watched outputs
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       slave_enable,
    input wire logic       settings_reset,
    input wire logic       reduced_power,
    input wire logic       interrupt_oe,
    input wire logic [7:0] status2
);
    localparam int LIM = INIT_CYC + 8;
    int unsigned low_cnt_reg;
    // Raw low time of the reset pin; the margin covers the synchroniser
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_reg <= 0;
        end else begin
            low_cnt_reg <= module_reset_pin_n ? 0 : low_cnt_reg + 1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_SDA: assert property (sda_oe |-> slave_enable && slave_sda_pull && !sda_out)
        else $error("data line driven");
    AST_DESEL: assert property (module_select_pin [*3] |-> !slave_enable)
        else $error("slave on while deselected");
    AST_LOW_POWER: assert property (low_power_request [*3] |-> reduced_power)
        else $error("no reduced power");
    AST_UP: assert property ($rose(nrst) |-> ##[1:LIM] (interrupt_oe && status2 == 8'h00))
        else $error("no power-up completion");
    AST_PIN_INIT: assert property ($rose(module_reset_pin_n) && settings_reset
        |-> ##[1:LIM] (interrupt_oe && status2 == 8'h00)) else $error("late completion");
    AST_HOLD: assert property (low_cnt_reg >= RESET_CYC + 4
        |-> settings_reset && status2 == 8'h01 && !interrupt_oe) else $error("reset not held");
    AST_FAULT: assert property (fault_event && !status2[0] |=> interrupt_oe)
        else $error("fault not flagged");
    AST_CLEAR: assert property (status2_read && !fault_event && !status2[0] |=> !interrupt_oe)
        else $error("interrupt not released");
endmodule // mcp_control_monitor
bind mcp_control mcp_control_monitor #(.INIT_CYC(INIT_CYC), .RESET_CYC(RESET_CYC))
    i_mcp_control_monitor (
    .core_clk           (core_clk),
    .nrst               (nrst),
    .module_reset_pin_n (module_reset_pin_n),
    .module_select_pin  (module_select_pin),
    .low_power_request  (low_power_request),
    .slave_sda_pull     (slave_sda_pull),
    .status2_read       (status2_read),
    .fault_event        (fault_event),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .slave_enable       (slave_enable),
    .settings_reset     (settings_reset),
    .reduced_power      (reduced_power),
    .interrupt_oe       (interrupt_oe),
    .status2            (status2)
);
`default_nettype wire

//--- verification/mcp_host_model.sv
// Host board model: line pull-ups and a status reader
`timescale 1ns/1ps
`default_nettype none
module mcp_host_model (
    // Clock and read enable
    input  wire logic core_clk,
    input  wire logic auto_read,
    // Module pins
    input  wire logic module_present_out,
    input  wire logic module_present_oe,
    input  wire logic interrupt_out,
    input  wire logic interrupt_oe,
    output logic      present_line,
    output logic      int_line,
    output logic      status2_read
);
    // Pull-ups win whenever the module lets go of a line
    assign present_line = module_present_oe ? module_present_out : 1'b1;
    assign int_line     = interrupt_oe ? interrupt_out : 1'b1;
    // Reads only while the line is low, so nothing is taken mid-reset
    always @(posedge core_clk) begin
        status2_read <= #2 auto_read && !int_line && !status2_read;
    end
endmodule // mcp_host_model
`default_nettype wire

//--- verification/test_module_control_pins.sv
// Self-checking bench for the control pin block
`timescale 1ns/1ps
`default_nettype none
module test_module_control_pins;
    import mcp_pkg::*;
    localparam int unsigned INIT_T = 10;
    logic core_clk = 1'b0, nrst = 1'b0, sel_en = 1'b0, sel_drv = 1'b0, module_reset_pin_n = 1'b1;
    logic low_power_request = 1'b0, scl_in = 1'b1, slave_sda_pull = 1'b0, fault_event = 1'b0;
    logic auto_read = 1'b1;
    wire logic module_select_pin, sda_in, sda_out, sda_oe, slave_enable, status2_read;
    wire logic settings_reset, reduced_power, module_present_out, module_present_oe;
    wire logic interrupt_out, interrupt_oe, present_line, int_line;
    wire logic [7:0] status2;
    logic [1:0] exp_q[$];
    int miscompares = 0, n_compared = 0, n;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %b", $time, a); end end
    // Clock, plus pull-ups on the select and data lines
    always #12.5 core_clk = ~core_clk;
    assign module_select_pin = sel_en ? sel_drv : 1'b1;
    assign sda_in = sda_oe ? sda_out : 1'b1;
    mcp_control #(.INIT_CYC(INIT_T), .RESET_CYC(4)) i_mcp_control (
        .core_clk           (core_clk),
        .nrst               (nrst),
        .module_select_pin  (module_select_pin),
        .module_reset_pin_n (module_reset_pin_n),
        .low_power_request  (low_power_request),
        .scl_in             (scl_in),
        .sda_in             (sda_in),
        .sda_out            (sda_out),
        .sda_oe             (sda_oe),
        .slave_enable       (slave_enable),
        .slave_sda_pull     (slave_sda_pull),
        .status2_read       (status2_read),
        .fault_event        (fault_event),
        .status2            (status2),
        .settings_reset     (settings_reset),
        .reduced_power      (reduced_power),
        .module_present_out (module_present_out),
        .module_present_oe  (module_present_oe),
        .interrupt_out      (interrupt_out),
        .interrupt_oe       (interrupt_oe)
    );
    mcp_host_model i_mcp_host_model (
        .core_clk           (core_clk),
        .auto_read          (auto_read),
        .module_present_out (module_present_out),
        .module_present_oe  (module_present_oe),
        .interrupt_out      (interrupt_out),
        .interrupt_oe       (interrupt_oe),
        .present_line       (present_line),
        .int_line           (int_line),
        .status2_read       (status2_read)
    );
    task automatic tick(int k);
        repeat (k) @(posedge core_clk);
        #2;
    endtask
    task automatic conclude();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog, well past the expected run
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
    // Each edge of the interrupt line takes the oldest note
    initial begin
        @(posedge nrst);
        forever begin
            @(int_line) #1;
            `CHK({int_line, status2[0]}, exp_q.size() ? exp_q.pop_front() : 2'bxx)
        end
    end
    initial begin
        void'($urandom(67338));
        exp_q = '{2'b00, 2'b10};
        tick(4);
        nrst = 1'b1;
        tick(INIT_T + 12);
        sel_en = 1'b1;
        repeat (12) begin
            {sel_drv, slave_sda_pull, low_power_request, scl_in} = 4'($urandom);
            tick(4);
            `CHK(slave_enable, !sel_drv)
            `CHK(sda_oe, !sel_drv && slave_sda_pull)
            `CHK(reduced_power, low_power_request)
        end
        sel_en = 1'b0;
        tick(4);
        `CHK(slave_enable, 1'b0)
        `CHK(present_line, 1'b0)
        // Fault with a prompt host, then with a slow one
        for (int s = 1; s >= 0; s--) begin
            auto_read = s[0];
            exp_q.push_back(2'b00);
            exp_q.push_back(2'b10);
            fault_event = 1'b1;
            tick(1);
            fault_event = 1'b0;
            tick(20);
            auto_read = 1'b1;
            tick(8);
        end
        // A pulse too short to count leaves the module running
        module_reset_pin_n = 1'b0;
        tick(2);
        module_reset_pin_n = 1'b1;
        tick(8);
        `CHK(status2, 8'h00)
        exp_q.push_back(2'b00);
        exp_q.push_back(2'b10);
        module_reset_pin_n = 1'b0;
        tick(30);
        `CHK({settings_reset, status2}, {1'b1, STATUS2_RESET})
        module_reset_pin_n = 1'b1;
        n = 0;
        while (int_line !== 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK(n inside {[INIT_T : INIT_T + 6]}, 1'b1)
        // Second power-up reset in mid-run
        tick(10);
        exp_q.push_back(2'b00);
        exp_q.push_back(2'b10);
        nrst = 1'b0;
        tick(3);
        nrst = 1'b1;
        tick(INIT_T + 12);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule // test_module_control_pins
`default_nettype wire
